// file: hsb_boot_seq.sv
// Boot sequencer and strap decoder for a four-port hub.
// Assumes straps settle before reset release and the flash answers
// in single or dual read as selected.
`timescale 1ns/10ps
`default_nettype none

module hsb_boot_seq
    import hsb_pkg::*;
(
    // Clock and chip reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Straps and analog levels
    input wire hsb_strap_t i_straps,
    // Flash options and clocking
    input wire logic i_spi_dual,
    input wire logic i_spi_mode3,
    input wire logic i_clk_valid,
    input wire logic i_pll_locked,
    // SoC register write
    input wire logic i_soc_wr,
    input wire logic [7:0] i_soc_addr,
    // Flash pins
    output logic o_spi_cs_n,
    output logic o_spi_clk,
    output logic o_spi_pins_oe,
    output logic o_spi_io0,
    output logic o_spi_io0_oe,
    input wire logic i_spi_io0,
    input wire logic i_spi_io1,
    // Status and configuration
    output hsb_stage_t o_stage,
    output hsb_cfg_t o_cfg,
    output logic o_cfg_valid,
    output logic o_pll_run,
    output logic o_ext_rom_en,
    output logic [15:0] o_fetch_addr,
    output logic [3:0] o_usb2_port_en,
    output logic [3:0] o_usb3_port_en
);
    hsb_stage_t stage_q;
    hsb_strap_t straps_q;
    logic cfg_step_q;
    logic probe_start_q;
    logic probe_done;
    logic probe_match;

    wire spi_mode = !straps_q.sdo_pullup && !straps_q.sclk_pullup; // [RQ16]
    wire smbus_mode = straps_q.sdo_pullup && straps_q.sclk_pullup; // [RQ16]
    wire soc_end = i_soc_wr && (i_soc_addr == SOC_END_REG); // [RQ17]
    // Off only when both lines are strapped off
    wire [3:0] port_off = straps_q.dplus_line_off_strap
                        & straps_q.dminus_line_off_strap; // [RQ1] [RQ2]
    wire [3:0] fixed_mask =
        level_mask(straps_q.fixed_port_count_strap); // [RQ3] [RQ18]
    wire [3:0] charge_mask =
        level_mask(straps_q.charge_port_count_strap); // [RQ4] [RQ18]

    // Async reset is the standby hold; every release restarts here
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stage_q <= ST_STANDBY; // [RQ6] [RQ19]
            straps_q <= '0;
            cfg_step_q <= 1'b0;
            probe_start_q <= 1'b0;
            o_stage <= ST_STANDBY;
            o_cfg <= '0; // [RQ8]
            o_cfg_valid <= 1'b0;
            o_pll_run <= 1'b0; // [RQ6]
            o_ext_rom_en <= 1'b0;
            o_fetch_addr <= 16'h0000;
            o_usb2_port_en <= 4'h0; // [RQ8]
            o_usb3_port_en <= 4'h0;
        end else begin
            probe_start_q <= 1'b0;
            unique case (stage_q)
                ST_STANDBY: begin
                    // Pins are caught at the first edge after release
                    straps_q <= i_straps; // [RQ5]
                    stage_q <= ST_SPI_INIT; // [RQ7] [RQ9]
                end
                ST_SPI_INIT: begin
                    o_cfg <= {DEF_PORT_OFF, DEF_FIXED, DEF_CHARGE,
                              1'b0}; // [RQ9]
                    o_pll_run <= i_clk_valid; // [RQ9]
                    if (i_pll_locked && o_pll_run) begin
                        if (spi_mode) begin
                            probe_start_q <= 1'b1;
                            stage_q <= ST_SIG_CHECK;
                        end else begin
                            stage_q <= ST_CFG_RD; // [RQ13]
                        end
                    end
                end
                ST_SIG_CHECK: begin
                    if (probe_done) begin
                        if (probe_match) begin
                            o_ext_rom_en <= 1'b1; // [RQ10]
                            o_fetch_addr <= EXT_BOOT_ADDR;
                            stage_q <= ST_EXT_ROM;
                        end else begin
                            stage_q <= ST_CFG_RD; // [RQ11]
                        end
                    end
                end
                ST_EXT_ROM: begin
                    // External code owns the device from here on
                    stage_q <= ST_EXT_ROM;
                end
                ST_CFG_RD: begin
                    cfg_step_q <= ~cfg_step_q;
                    if (!cfg_step_q) begin
                        o_cfg <= {DEF_PORT_OFF, DEF_FIXED, DEF_CHARGE,
                                  1'b0}; // [RQ14]
                    end else begin
                        o_cfg <= {port_off, fixed_mask, charge_mask,
                                  1'b0}; // [RQ14]
                        o_cfg_valid <= 1'b1;
                        o_usb2_port_en <= ~port_off; // [RQ2]
                        o_usb3_port_en <= ~port_off; // [RQ2]
                        stage_q <= ST_STRAP_RD;
                    end
                end
                ST_STRAP_RD: begin
                    o_cfg.smbus_mode <= smbus_mode; // [RQ15]
                    stage_q <= smbus_mode ? ST_SOC_CFG
                                          : ST_OTP_CFG; // [RQ15]
                end
                ST_SOC_CFG: begin
                    // No timeout: the SoC may take as long as it likes
                    if (soc_end) stage_q <= ST_OTP_CFG; // [RQ17]
                end
                ST_OTP_CFG: begin
                    stage_q <= ST_OTP_CFG;
                end
            endcase
            o_stage <= stage_q;
        end
    end

    hsb_flash_probe u_probe (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_start(probe_start_q),
        .i_dual(i_spi_dual),
        .i_mode3(i_spi_mode3),
        .o_done(probe_done),
        .o_match(probe_match),
        .o_cs_n(o_spi_cs_n),
        .o_sclk(o_spi_clk),
        .o_pins_oe(o_spi_pins_oe),
        .o_io0(o_spi_io0),
        .o_io0_oe(o_spi_io0_oe),
        .i_io0(i_spi_io0),
        .i_io1(i_spi_io1)
    );

    // Checks
    sequence s_cfg_default;
        stage_q == ST_CFG_RD && !cfg_step_q;
    endsequence

    sequence s_cfg_apply;
        stage_q == ST_CFG_RD && cfg_step_q;
    endsequence

    property p_standby_first;
        @(posedge i_clk) $rose(i_nrst) |-> stage_q == ST_STANDBY;
    endproperty
    a_standby_first: assert property (p_standby_first) // [RQ19]
        else $error("boot did not start in standby");

    property p_strap_hold;
        @(posedge i_clk) disable iff (!i_nrst)
        stage_q != ST_STANDBY |=> $stable(straps_q);
    endproperty
    a_strap_hold: assert property (p_strap_hold) // [RQ5]
        else $error("captured straps changed");

    property p_port_off;
        @(posedge i_clk) disable iff (!i_nrst)
        s_cfg_apply |=> o_usb2_port_en == ~(straps_q.dplus_line_off_strap
            & straps_q.dminus_line_off_strap) && o_usb3_port_en
            == o_usb2_port_en;
    endproperty
    a_port_off: assert property (p_port_off) // [RQ2]
        else $error("port enable mismatch");

    property p_default_then_strap;
        @(posedge i_clk) disable iff (!i_nrst)
        s_cfg_default ##1 s_cfg_apply |=> o_cfg.fixed_mask ==
            level_mask(straps_q.fixed_port_count_strap) &&
            o_cfg.charge_mask ==
            level_mask(straps_q.charge_port_count_strap);
    endproperty
    a_default_then_strap: assert property (p_default_then_strap) // [RQ14]
        else $error("strap override not applied");

    property p_cfg_default;
        @(posedge i_clk) disable iff (!i_nrst)
        s_cfg_default |=> o_cfg == {DEF_PORT_OFF, DEF_FIXED, DEF_CHARGE,
            1'b0};
    endproperty
    a_cfg_default: assert property (p_cfg_default) // [RQ14]
        else $error("defaults not loaded first");

    property p_skip_check;
        @(posedge i_clk) disable iff (!i_nrst)
        stage_q == ST_SPI_INIT && !spi_mode && i_pll_locked && o_pll_run
        |=> stage_q == ST_CFG_RD && !o_ext_rom_en;
    endproperty
    a_skip_check: assert property (p_skip_check) // [RQ13]
        else $error("probe not skipped outside flash mode");

    property p_sig_result;
        @(posedge i_clk) disable iff (!i_nrst)
        stage_q == ST_SIG_CHECK && probe_done |=>
            (probe_match ? stage_q == ST_EXT_ROM && o_fetch_addr == 16'h0000
                         : stage_q == ST_CFG_RD);
    endproperty
    a_sig_result: assert property (p_sig_result) // [RQ10] [RQ11]
        else $error("wrong branch after signature check");

    property p_strap_branch;
        @(posedge i_clk) disable iff (!i_nrst)
        stage_q == ST_STRAP_RD |=>
            stage_q == (smbus_mode ? ST_SOC_CFG : ST_OTP_CFG);
    endproperty
    a_strap_branch: assert property (p_strap_branch) // [RQ15]
        else $error("wrong stage after strap read");

    property p_soc_wait;
        @(posedge i_clk) disable iff (!i_nrst)
        stage_q == ST_SOC_CFG && !soc_end |=> stage_q == ST_SOC_CFG;
    endproperty
    a_soc_wait: assert property (p_soc_wait) // [RQ17]
        else $error("SoC stage left without end write");

    property p_pins_released;
        @(posedge i_clk) disable iff (!i_nrst)
        stage_q == ST_SPI_INIT |-> !o_spi_pins_oe && !o_spi_io0_oe
            && o_usb2_port_en == 4'h0;
    endproperty
    a_pins_released: assert property (p_pins_released) // [RQ6] [RQ8]
        else $error("pins driven before boot");
endmodule

`default_nettype wire

// file: hsb_flash_model.sv
// Behavioural serial flash that holds the boot signature.
// Assumes the reader samples on rising clock edges and owns io0 until
// the data phase of a dual read.
`timescale 1ns/10ps
`default_nettype none

module hsb_flash_model (
    // Flash pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_io0,
    output logic o_io0,
    output logic o_io0_oe,
    output logic o_io1,
    // Test control and observation
    input wire logic i_sig_ok,
    output logic [7:0] o_cmd,
    output logic [23:0] o_addr
);
    int rcnt = 0;
    int k;
    logic [31:0] sh = 32'h0;
    logic [31:0] word = 32'h0;
    logic is_dual;

    // A bad image differs in its last signature byte only
    function automatic logic [7:0] byte_at(input logic [23:0] a);
        case (a)
            24'h00fffa: byte_at = 8'h32;
            24'h00fffb: byte_at = 8'h44;
            24'h00fffc: byte_at = 8'h46;
            24'h00fffd: byte_at = i_sig_ok ? 8'h55 : 8'h56;
            default: byte_at = 8'hff;
        endcase
    endfunction

    initial begin
        o_io0 = 1'b0;
        o_io1 = 1'b0;
        o_io0_oe = 1'b0;
        o_cmd = 8'h00;
        o_addr = 24'h000000;
    end

    always @(negedge i_cs_n) rcnt = 0;

    // Nothing pulls these lines, so show a flipped value, not the last bit
    always @(posedge i_cs_n) begin
        o_io0_oe = 1'b0;
        o_io0 = ~o_io0;
        o_io1 = ~o_io1;
    end

    always @(posedge i_sclk) if (!i_cs_n) begin
        sh = {sh[30:0], i_io0};
        if (rcnt == 7) o_cmd = sh[7:0];
        if (rcnt == 31) begin
            o_addr = sh[23:0];
            word = {byte_at(sh[23:0]), byte_at(sh[23:0] + 24'h1),
                    byte_at(sh[23:0] + 24'h2), byte_at(sh[23:0] + 24'h3)};
        end
        rcnt++;
    end

    // Data moves on the falling edge in mode 0 and mode 3 alike
    always @(negedge i_sclk) if (!i_cs_n) begin
        is_dual = (o_cmd == 8'h3b);
        k = rcnt - (is_dual ? 40 : 32);
        if (is_dual && k >= 0 && k < 16) begin
            o_io0_oe = 1'b1;
            o_io1 = word[31-2*k];
            o_io0 = word[30-2*k];
        end else if (!is_dual && k >= 0 && k < 32) begin
            o_io1 = word[31-k];
        end
    end
endmodule

`default_nettype wire

// file: hsb_flash_probe.sv
// Package for the strap and boot sequencer, and the flash signature probe.
// Assumes a single 100 MHz clock and flash pins sampled synchronously.
// Contract
// RQ1 - Per-port D+ and D- off straps read
// RQ2 - Port off only when both straps high
// RQ3 - Fixed-port strap level selects ports one-four
// RQ4 - Charge strap level selects ports one-four
// RQ5 - Straps captured at reset release, then held
// RQ6 - Reset low: standby, pins released, PLL stopped
// RQ7 - Reset high: hub mode walks boot stages
// RQ8 - Standby disables ports, resets all state
// RQ9 - Release enters flash init, PLL locks, defaults
// RQ10 - Signature at 0xFFFA enables external ROM
// RQ11 - Signature miss continues to configuration read
// RQ12 - Flash reader supports single/dual, mode 0/3
// RQ13 - Not flash mode: skip check, configuration read
// RQ14 - Load defaults first, then strap overrides
// RQ15 - Strap read picks SoC or OTP stage
// RQ16 - Both pulled: SMBus; neither pulled: flash mode
// RQ17 - SoC stage waits for write to 0xFF
// RQ18 - Level code 0-4; others mean none
// RQ19 - One state machine, restarts on every release
package hsb_pkg;
    localparam int NPORT = 4;
    localparam logic [7:0] FL_CMD_SINGLE = 8'h03;
    localparam logic [7:0] FL_CMD_DUAL = 8'h3b;
    localparam logic [23:0] FL_SIG_ADDR = 24'h00fffa;
    localparam logic [31:0] FL_SIG = 32'h32444655;
    localparam logic [15:0] EXT_BOOT_ADDR = 16'h0000;
    localparam logic [7:0] SOC_END_REG = 8'hff;
    localparam int TX_BITS_SINGLE = 32;
    localparam int TX_BITS_DUAL = 40;
    localparam int RX_CLKS_SINGLE = 32;
    localparam int RX_CLKS_DUAL = 16;
    localparam int SCLK_HALF_CYC = 2;
    localparam logic [3:0] DEF_PORT_OFF = 4'h0;
    localparam logic [3:0] DEF_FIXED = 4'h0;
    localparam logic [3:0] DEF_CHARGE = 4'h0;

    typedef enum logic [2:0] {
        ST_STANDBY, ST_SPI_INIT, ST_SIG_CHECK, ST_EXT_ROM,
        ST_CFG_RD, ST_STRAP_RD, ST_SOC_CFG, ST_OTP_CFG
    } hsb_stage_t;

    typedef struct packed {
        logic [3:0] dplus_line_off_strap;
        logic [3:0] dminus_line_off_strap;
        logic [2:0] fixed_port_count_strap;
        logic [2:0] charge_port_count_strap;
        logic sdo_pullup;
        logic sclk_pullup;
    } hsb_strap_t;

    typedef struct packed {
        logic [3:0] port_off;
        logic [3:0] fixed_mask;
        logic [3:0] charge_mask;
        logic smbus_mode;
    } hsb_cfg_t;

    // Five-level strap to port mask; stray codes read as no ports
    function automatic logic [3:0] level_mask(input logic [2:0] code);
        unique case (code)
            3'h1: level_mask = 4'h1;
            3'h2: level_mask = 4'h3;
            3'h3: level_mask = 4'h7;
            3'h4: level_mask = 4'hf;
            default: level_mask = 4'h0;
        endcase
    endfunction
endpackage

`timescale 1ns/10ps
`default_nettype none

module hsb_flash_probe
    import hsb_pkg::*;
#(
    parameter int HALF = SCLK_HALF_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Control
    input wire logic i_start,
    input wire logic i_dual,
    input wire logic i_mode3,
    output logic o_done,
    output logic o_match,
    // Flash pins
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_pins_oe,
    output logic o_io0,
    output logic o_io0_oe,
    input wire logic i_io0,
    input wire logic i_io1
);
    // The divider is eight bits wide, so the half period is capped
    if (HALF < 1 || HALF > 256) begin : g_bad_half
        $error("HALF must be 1 to 256");
    end

    logic [7:0] div_q;
    logic busy_q;
    logic phase_q;
    logic [6:0] cnt_q;
    logic [39:0] tx_q;
    logic [31:0] rx_q;
    logic dual_q;
    wire tick = busy_q && (div_q == 8'(HALF - 1));
    wire [6:0] tx_n = dual_q ? 7'(TX_BITS_DUAL) : 7'(TX_BITS_SINGLE);
    wire [6:0] total = tx_n + (dual_q ? 7'(RX_CLKS_DUAL) : 7'(RX_CLKS_SINGLE));
    wire in_rx = cnt_q >= tx_n;
    wire last = phase_q && (cnt_q == total - 7'h01);
    // Dual reads take two bits per clock, io1 the higher
    wire [31:0] rx_d = dual_q ? {rx_q[29:0], i_io1, i_io0}
                              : {rx_q[30:0], i_io1};

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div_q <= 8'h00;
        end else begin
            div_q <= (!busy_q || tick) ? 8'h00 : div_q + 8'h01;
        end
    end

    // Data launched with sclk low, sampled on rising edge: mode 0 and 3
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_q <= 1'b0;
            phase_q <= 1'b0;
            cnt_q <= 7'h00;
            tx_q <= 40'h0;
            rx_q <= 32'h0;
            dual_q <= 1'b0;
            o_cs_n <= 1'b1;
            o_sclk <= 1'b0;
            o_pins_oe <= 1'b0;
            o_io0 <= 1'b0;
            o_io0_oe <= 1'b0;
            o_done <= 1'b0;
            o_match <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !busy_q) begin
                busy_q <= 1'b1;
                dual_q <= i_dual; // [RQ12]
                tx_q <= {i_dual ? FL_CMD_DUAL : FL_CMD_SINGLE,
                         FL_SIG_ADDR, 8'h00}; // [RQ10]
                cnt_q <= 7'h00;
                phase_q <= 1'b0;
                o_cs_n <= 1'b0;
                o_sclk <= i_mode3; // [RQ12]
                o_pins_oe <= 1'b1;
                o_io0_oe <= 1'b1;
            end else if (tick) begin
                phase_q <= ~phase_q;
                if (!phase_q) begin
                    o_sclk <= 1'b0;
                    o_io0 <= tx_q[39];
                    tx_q <= {tx_q[38:0], 1'b0};
                    o_io0_oe <= !(dual_q && in_rx);
                end else begin
                    o_sclk <= 1'b1;
                    if (in_rx) rx_q <= rx_d;
                    cnt_q <= cnt_q + 7'h01;
                    if (last) begin
                        busy_q <= 1'b0;
                        // Clock stays high over the last sample edge
                        o_cs_n <= 1'b1;
                        o_io0_oe <= 1'b0;
                        o_done <= 1'b1;
                        o_match <= (rx_d == FL_SIG); // [RQ10]
                    end
                end
            end else if (!busy_q) begin
                // Park at idle level before select falls: no stray edge
                o_sclk <= i_mode3; // [RQ12]
            end
        end
    end
endmodule

`default_nettype wire

// file: tb.sv
// Self-checking bench for the strap decoder and boot sequencer.
// Assumes the flash model file is compiled before this one.
`timescale 1ns/10ps
`default_nettype none

module tb;
    import hsb_pkg::*;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    hsb_strap_t straps = '0;
    logic dual = 1'b0;
    logic mode3 = 1'b0;
    logic clk_valid = 1'b1;
    logic pll_locked = 1'b1;
    logic soc_wr = 1'b0;
    logic [7:0] soc_addr = 8'h00;
    logic sig_ok = 1'b1;
    logic cs_n, sclk, pins_oe, d_io0, d_io0_oe, f_io0, f_io0_oe, f_io1;
    logic io0_w, cfg_valid, pll_run, ext_rom_en;
    hsb_stage_t stage;
    hsb_cfg_t cfg;
    logic [15:0] fetch_addr;
    logic [3:0] usb2_en, usb3_en;
    logic [7:0] fl_cmd;
    logic [23:0] fl_addr;
    hsb_strap_t s;
    int err_total = 0;
    int n_tests = 0;

    always #5 i_clk = ~i_clk;
    // Both ends driving io0 at once shows up as an unknown bit
    assign io0_w = (d_io0_oe && f_io0_oe) ? 1'bx : (d_io0_oe ? d_io0 : f_io0);

    hsb_boot_seq DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_straps(straps),
        .i_spi_dual(dual), .i_spi_mode3(mode3), .i_clk_valid(clk_valid),
        .i_pll_locked(pll_locked), .i_soc_wr(soc_wr), .i_soc_addr(soc_addr),
        .o_spi_cs_n(cs_n), .o_spi_clk(sclk), .o_spi_pins_oe(pins_oe),
        .o_spi_io0(d_io0), .o_spi_io0_oe(d_io0_oe), .i_spi_io0(io0_w),
        .i_spi_io1(f_io1), .o_stage(stage), .o_cfg(cfg),
        .o_cfg_valid(cfg_valid), .o_pll_run(pll_run),
        .o_ext_rom_en(ext_rom_en), .o_fetch_addr(fetch_addr),
        .o_usb2_port_en(usb2_en), .o_usb3_port_en(usb3_en));

    hsb_flash_model flash (.i_cs_n(cs_n), .i_sclk(sclk), .i_io0(io0_w),
        .o_io0(f_io0), .o_io0_oe(f_io0_oe), .o_io1(f_io1),
        .i_sig_ok(sig_ok), .o_cmd(fl_cmd), .o_addr(fl_addr));

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_clk);
            #1;
        end
    endtask

    // Bounded wait; the final compare flags a stage never reached
    task automatic wait_stage(input hsb_stage_t st, input int maxc);
        int n;
        n = 0;
        while (stage !== st && n < maxc) begin
            tick(1);
            n++;
        end
        chk(stage, st);
    endtask

    task automatic boot(input hsb_strap_t v, input logic d, input logic m3);
        @(posedge i_clk);
        i_nrst <= 1'b0;
        straps <= v;
        dual <= d;
        mode3 <= m3;
        tick(2);
        chk({cs_n, pins_oe, sclk, d_io0_oe, pll_run}, 32'h10);
        chk({stage, cfg, cfg_valid, ext_rom_en}, 32'h0);
        chk({usb2_en, usb3_en, fetch_addr}, 32'h0);
        @(posedge i_clk);
        i_nrst <= 1'b1;
        tick(1);
        wait_stage(ST_SPI_INIT, 2);
    endtask

    task automatic soc_write(input logic [7:0] a);
        @(posedge i_clk);
        soc_wr <= 1'b1;
        soc_addr <= a;
        @(posedge i_clk);
        soc_wr <= 1'b0;
        tick(1);
    endtask

    function automatic logic [3:0] lvl(input logic [2:0] c);
        return (c > 3'h4) ? 4'h0 : 4'((5'h1 << c) - 5'h1);
    endfunction

    function automatic logic [31:0] exp_cfg(input hsb_strap_t v);
        logic [3:0] off;
        off = v.dplus_line_off_strap & v.dminus_line_off_strap;
        return {19'h0, off, lvl(v.fixed_port_count_strap),
                lvl(v.charge_port_count_strap), v.sdo_pullup & v.sclk_pullup};
    endfunction

    // Work through a strap set after the configuration stages
    task automatic chk_cfg(input hsb_strap_t v);
        logic [3:0] on;
        on = ~(v.dplus_line_off_strap & v.dminus_line_off_strap);
        chk(cfg, exp_cfg(v));
        chk({usb2_en, usb3_en, cfg_valid}, {23'h0, on, on, 1'b1});
    endtask

    initial begin
        // Well beyond ten boots with a full flash probe each
        #200000;
        err_total++;
        results();
    end

    initial begin
        tick(5);
        // One pull-up only: no flash probe, straight to OTP
        for (int c = 0; c < 8; c++) begin
            s = '0;
            s.dplus_line_off_strap = 4'(c * 3);
            s.dminus_line_off_strap = 4'(c * 5 + 1);
            s.fixed_port_count_strap = 3'(c);
            s.charge_port_count_strap = 3'(7 - c);
            s.sdo_pullup = 1'b1;
            boot(s, 1'b0, 1'b0);
            wait_stage(ST_CFG_RD, 4);
            wait_stage(ST_OTP_CFG, 6);
            chk_cfg(s);
            chk({cs_n, ext_rom_en}, 32'h2);
            @(posedge i_clk);
            straps <= ~s;
            tick(3);
            chk_cfg(s);
        end
        $display("test strap levels done");

        s = '0;
        s.dplus_line_off_strap = 4'ha;
        s.dminus_line_off_strap = 4'h6;
        s.fixed_port_count_strap = 3'h4;
        s.charge_port_count_strap = 3'h2;
        s.sdo_pullup = 1'b1;
        s.sclk_pullup = 1'b1;
        boot(s, 1'b0, 1'b0);
        wait_stage(ST_SOC_CFG, 10);
        chk_cfg(s);
        soc_write(8'h7f);
        tick(5);
        chk(stage, ST_SOC_CFG);
        soc_write(8'hff);
        wait_stage(ST_OTP_CFG, 3);
        $display("test soc stage done");

        s = '0;
        for (int i = 0; i < 5; i++) begin
            sig_ok <= (i < 4);
            boot(s, i[0], i[1]);
            wait_stage(ST_SIG_CHECK, 6);
            if (i < 4) begin
                wait_stage(ST_EXT_ROM, 400);
                chk({ext_rom_en, fetch_addr}, 32'h10000);
                chk(fl_cmd, i[0] ? FL_CMD_DUAL : FL_CMD_SINGLE);
            end else begin
                wait_stage(ST_CFG_RD, 400);
                wait_stage(ST_OTP_CFG, 6);
                chk_cfg(s);
                chk(ext_rom_en, 32'h0);
            end
            chk(fl_addr, 32'h00fffa);
            chk({cs_n, sclk, pins_oe}, {29'h0, 1'b1, i[1], 1'b1});
        end
        $display("test flash probe done");

        sig_ok <= 1'b1;
        boot(s, 1'b1, 1'b0);
        wait_stage(ST_SIG_CHECK, 6);
        tick(50);
        @(posedge i_clk);
        clk_valid <= 1'b0;
        boot(s, 1'b0, 1'b1);
        tick(20);
        chk({stage, pll_run}, {28'h0, ST_SPI_INIT, 1'b0});
        @(posedge i_clk);
        clk_valid <= 1'b1;
        wait_stage(ST_SIG_CHECK, 6);
        chk(pll_run, 32'h1);
        wait_stage(ST_EXT_ROM, 400);
        $display("test reset in mid-probe done");
        results();
    end
endmodule

`default_nettype wire
